// ===== hdl/clock_divider.sv
// Programmable divider: one-cycle tick every divisor cycles of clk
`timescale 1ns/1ps
module clock_divider #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  tick
);
    logic [WIDTH-1:0] count_q;

    // ------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------
    // Divisor 0 holds the tick low: a stopped output, not a runaway one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else if (divisor == '0) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else if (count_q == '0 || count_q >= divisor) begin
            count_q <= divisor - WIDTH'(1);
            tick    <= 1'b1;
        end else begin
            count_q <= count_q - WIDTH'(1);
            tick    <= 1'b0;
        end
    end
endmodule

// ===== hdl/tone_pkg.sv
// Package: constants and carrier types for the serial tone divider program block
package tone_pkg;

    // ------------------------------------------------------------
    // Program word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS     = 32;
    localparam int TONE_LSB      = 0;
    localparam int TONE_BITS     = 16;
    localparam int SAMPLE_LSB    = 16;
    localparam int SAMPLE_BITS   = 12;
    localparam int ATTEN_LSB     = 28;
    localparam int ATTEN_BITS    = 4;
    localparam int SYNC_STAGES   = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [WORD_BITS-1:0]   WORD_RESET   = 32'h0000_0000;
    localparam logic [TONE_BITS-1:0]   TONE_RESET   = 16'h0000;
    localparam logic [SAMPLE_BITS-1:0] SAMPLE_RESET = 12'h000;
    localparam logic [ATTEN_BITS-1:0]  ATTEN_RESET  = 4'h0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic write_select_n;
        logic bit_shift_clock;
        logic serial_data;
    } serial_pins_t;

    typedef struct packed {
        logic [ATTEN_BITS-1:0]  level_attenuation_field;
        logic [SAMPLE_BITS-1:0] sample_divisor_field;
        logic [TONE_BITS-1:0]   tone_divisor_field;
    } program_t;

    typedef struct packed {
        logic                  square_tone;
        logic                  sample_clock;
        logic [ATTEN_BITS-1:0] attenuation_db;
    } tone_out_t;

endpackage

// ===== hdl/tone_program.sv
// Serial program port, latches and tone/sample dividers of the tone generator core
`timescale 1ns/1ps
// Summary of operation
// - Configuration arrives as one 32-bit serial word into a shift register.
// - Each shift clock pulse while write-select is low moves exactly one data bit into the register.
// - Write-select rising edge after 32 bits copies shift register into latches.
// - Tone divider divides master clock by latched bits 0 to 15.
// - Divide-by-two stage follows tone divider giving even duty square tone.
// - Separate second counter produces the filter sampling clock.
// - Attenuation has 16 settings of 1 dB, from bits 28 upward.
// - Bits 28..31 weigh 1, 2, 4, 8 dB; zero means none.
module tone_program
    import tone_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire tone_pkg::serial_pins_t  pins,
    output tone_pkg::tone_out_t          tone_out,
    output tone_pkg::program_t           program_word,
    output logic                         word_loaded
);
    import tone_pkg::*;

    // ------------------------------------------------------------
    // Port state machine type
    // ------------------------------------------------------------
    // Idle: select high; wait: select low, shift clock not yet low;
    // shift: collecting bits; full: a whole word sits in the register
    typedef enum logic [3:0] {
        PORT_IDLE  = 4'b0001,
        PORT_WAIT  = 4'b0010,
        PORT_SHIFT = 4'b0100,
        PORT_FULL  = 4'b1000
    } port_state_t;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    serial_pins_t                  sync1_q;
    serial_pins_t                  sync2_q;
    serial_pins_t                  prev_q;
    port_state_t                   state_q;
    port_state_t                   state_d;
    logic                          shift_rise;
    logic                          select_rise;
    logic                          shift_take;
    logic                          last_bit;
    logic [WORD_BITS-1:0]          shift_q;
    logic [5:0]                    count_q;
    program_t                      latch_q;
    logic                          loaded_q;
    logic                          tone_tick;
    logic                          sample_tick;
    logic                          square_q;
    logic                          sample_q;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Rising edge between two synchronised samples of one pin
    function automatic logic rose(input logic now_level, input logic old_level);
        return now_level & ~old_level;
    endfunction

    // Splits a complete shift register image into the latched fields
    function automatic program_t split_word(input logic [WORD_BITS-1:0] word);
        program_t fields;
        fields.tone_divisor_field      = word[TONE_LSB +: TONE_BITS];
        fields.sample_divisor_field    = word[SAMPLE_LSB +: SAMPLE_BITS];
        fields.level_attenuation_field = word[ATTEN_LSB +: ATTEN_BITS];
        return fields;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pins come from another party's logic, so two flops before any use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= serial_pins_t'(3'b100);
            sync2_q <= serial_pins_t'(3'b100);
            prev_q  <= serial_pins_t'(3'b100);
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Shift clock rise only counts while write-select is low
    assign shift_rise  = rose(sync2_q.bit_shift_clock, prev_q.bit_shift_clock)
                       & ~sync2_q.write_select_n;
    assign select_rise = rose(sync2_q.write_select_n, prev_q.write_select_n);

    // Bits count only once the start condition has been seen
    assign shift_take = shift_rise & (state_q == PORT_SHIFT || state_q == PORT_FULL);
    assign last_bit   = shift_take && count_q == 6'(WORD_BITS - 1);

    // ------------------------------------------------------------
    // Port state machine
    // ------------------------------------------------------------
    // A clock already high when select falls would fake a first bit
    always_comb begin
        state_d = state_q;
        case (state_q)
            PORT_IDLE: begin
                if (!sync2_q.write_select_n && sync2_q.bit_shift_clock) begin
                    state_d = PORT_WAIT;
                end else if (!sync2_q.write_select_n) begin
                    state_d = PORT_SHIFT;
                end
            end
            PORT_WAIT: begin
                if (sync2_q.write_select_n) begin
                    state_d = PORT_IDLE;
                end else if (!sync2_q.bit_shift_clock) begin
                    state_d = PORT_SHIFT;
                end
            end
            PORT_SHIFT: begin
                if (sync2_q.write_select_n) begin
                    state_d = PORT_IDLE;
                end else if (last_bit) begin
                    state_d = PORT_FULL;
                end
            end
            PORT_FULL: begin
                if (sync2_q.write_select_n) begin
                    state_d = PORT_IDLE;
                end
            end
            default: begin
                state_d = PORT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= PORT_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    // Bit 0 goes first, so new bits enter at the top and move down
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= WORD_RESET;
        end else if (shift_take) begin
            shift_q <= {sync2_q.serial_data, shift_q[WORD_BITS-1:1]};
        end
    end

    // Counts bits since the sequence opened; saturates so extra pulses are harmless
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 6'h00;
        end else if (state_q == PORT_IDLE) begin
            count_q <= 6'h00;
        end else if (shift_take && count_q != 6'(WORD_BITS)) begin
            count_q <= count_q + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Program latches
    // ------------------------------------------------------------
    // A short word is discarded so the dividers never see a half-shifted value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_q  <= program_t'({ATTEN_RESET, SAMPLE_RESET, TONE_RESET});
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= 1'b0;
            if (select_rise && state_q == PORT_FULL) begin
                latch_q  <= split_word(shift_q);
                loaded_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------
    clock_divider #(.WIDTH(TONE_BITS)) tone_div (
        .clk     (clk),
        .resetn  (resetn),
        .divisor (latch_q.tone_divisor_field),
        .tick    (tone_tick)
    );

    clock_divider #(.WIDTH(SAMPLE_BITS)) sample_div (
        .clk     (clk),
        .resetn  (resetn),
        .divisor (latch_q.sample_divisor_field),
        .tick    (sample_tick)
    );

    // Toggle stages: the divide-by-two makes both outputs symmetrical
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            square_q <= 1'b0;
        end else if (tone_tick) begin
            square_q <= ~square_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_q <= 1'b0;
        end else if (sample_tick) begin
            sample_q <= ~sample_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Binary field is the dB figure directly: weights 1, 2, 4, 8
    assign tone_out     = '{square_tone:    square_q,
                            sample_clock:   sample_q,
                            attenuation_db: latch_q.level_attenuation_field};
    assign program_word = latch_q;
    assign word_loaded             = loaded_q;
endmodule

// ===== verif/serial_ctrl_model.sv
// Controller model driving the serial program pins
`timescale 1ns/1ps
module serial_ctrl_model
    import tone_pkg::*;
(
    input  wire logic              clk,
    output tone_pkg::serial_pins_t pins
);
    initial pins = 3'b100;
    task automatic hold;
        repeat (4) @(negedge clk);
    endtask
    // Lsb first; sel low leaves write-select high so pulses must be ignored
    task automatic send(input logic [39:0] w, input int n, input bit sel);
        pins.write_select_n = !sel;
        pins.bit_shift_clock = 1'b0;
        hold();
        for (int i = 0; i < n; i++) begin
            pins.serial_data = w[i];
            hold();
            pins.bit_shift_clock = 1'b1;
            hold();
            pins.bit_shift_clock = 1'b0;
            hold();
        end
        pins.write_select_n = 1'b1;
        hold();
        // Released line must not keep showing the last bit
        pins.serial_data = !pins.serial_data;
    endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the tone program core
`timescale 1ns/1ps
module testbench;
    import tone_pkg::*;
    logic         clk;
    logic         resetn;
    serial_pins_t pins;
    tone_out_t    tone_out;
    program_t     program_word;
    logic         word_loaded;
    int           errors;
    int           cmp_count;
    int           cyc;
    int           loads;
    tone_program tone_program_inst (.clk(clk), .resetn(resetn), .pins(pins), .tone_out(tone_out),
        .program_word(program_word), .word_loaded(word_loaded));
    serial_ctrl_model serial_ctrl_model_inst (.clk(clk), .pins(pins));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (word_loaded === 1'b1)
            loads++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Compares %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic pick(input bit s);
        return s ? tone_out.sample_clock : tone_out.square_tone;
    endfunction
    // Early intervals skipped, reload may stretch them
    task automatic half_period(input bit s, output int n);
        logic v;
        repeat (4) begin
            n = 0;
            v = pick(s);
            while (pick(s) === v && n < 4000) begin
                @(negedge clk);
                n++;
            end
        end
    endtask
    task automatic load_and_run(input logic [39:0] w, input int nb);
        int          n;
        int          l0;
        logic [31:0] e;
        l0 = loads;
        e = 32'(w >> (nb - 32));
        serial_ctrl_model_inst.send(w, nb, 1'b1);
        check(32'(loads), 32'(l0 + 1));
        check(program_word, e);
        check(32'(tone_out.attenuation_db), 32'(e[31:28]));
        half_period(1'b0, n);
        check(32'(n), 32'(e[15:0]));
        half_period(1'b1, n);
        check(32'(n), 32'(e[27:16]));
    endtask
    task automatic refused_short;
        int          l0;
        logic [31:0] old;
        l0 = loads;
        old = program_word;
        serial_ctrl_model_inst.send(40'hFF_FFFF_FFFF, 8, 1'b0);
        serial_ctrl_model_inst.send(40'h00_8123_4567, 31, 1'b1);
        check(32'(loads), 32'(l0));
        check(program_word, old);
    endtask
    initial begin
        resetn = 1'b0;
        errors = 0;
        cmp_count = 0;
        cyc = 0;
        loads = 0;
        repeat (3) @(negedge clk);
        check({26'h0, tone_out}, 32'h0000_0000);
        check(program_word, 32'h0000_0000);
        check(32'(word_loaded), 32'h0000_0000);
        resetn = 1'b1;
        for (int i = 0; i < 5; i++)
            load_and_run({8'h00, 4'(1 << i), 12'(3 + i), 16'(5 + i)}, 32);
        refused_short();
        load_and_run({32'h7006_0009, 8'hC3}, 40);
        wrap_up();
    end
endmodule

// ===== verif/tone_program_chk.sv
// Checker for load pulse, latches and tone divider timing
`timescale 1ns/1ps
module tone_program_chk
    import tone_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire tone_pkg::serial_pins_t pins,
    input wire tone_pkg::tone_out_t    tone_out,
    input wire tone_pkg::program_t     program_word,
    input wire logic                   word_loaded
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [15:0] sq_q;
    logic [1:0]  seen_q;
    // First toggles after a load may follow the old divisor
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sq_q   <= 16'h0000;
            seen_q <= 2'h0;
        end else begin
            sq_q   <= $changed(tone_out.square_tone) ? 16'h0001 : sq_q + 16'h0001;
            if (word_loaded)
                seen_q <= 2'h0;
            else if ($changed(tone_out.square_tone) && seen_q != 2'h3)
                seen_q <= seen_q + 2'h1;
        end
    end
    sequence one_pulse;
        word_loaded ##1 !word_loaded;
    endsequence
    pulse_width_a: assert property ($rose(word_loaded) |-> one_pulse)
        else $error("load pulse longer than one cycle");
    load_release_a: assert property (word_loaded |-> $past(pins.write_select_n, 2) &&
        !$past(pins.write_select_n, 5)) else $error("load not 3 to 4 cycles after select rise");
    select_low_a: assert property (!pins.write_select_n [*5] |-> !word_loaded)
        else $error("load while select low");
    atten_tracks_a: assert property (tone_out.attenuation_db == program_word.level_attenuation_field)
        else $error("attenuation differs from latch");
    latch_holds_a: assert property ($changed(program_word) |-> word_loaded)
        else $error("latch changed without load");
    tone_period_a: assert property ($changed(tone_out.square_tone) && seen_q == 2'h3 |->
        sq_q == program_word.tone_divisor_field) else $error("square half period wrong");
    tone_frozen_a: assert property ((program_word.tone_divisor_field == 16'h0000) [*3] |->
        $stable(tone_out.square_tone)) else $error("square moves with zero divisor");
    sample_runs_a: assert property ($changed(tone_out.sample_clock) |->
        program_word.sample_divisor_field != 12'h000) else $error("sample clock moves with zero divisor");
endmodule
bind tone_program tone_program_chk tone_program_chk_inst (.clk(clk), .resetn(resetn), .pins(pins),
    .tone_out(tone_out), .program_word(program_word), .word_loaded(word_loaded));
